// >>> core/sau_unit.sv
// accumulator loop and concurrent multiply/divide element
// What this block does
// - add/subtract and multiply/divide run concurrently
// - simple ops alter only the stored operand
// - counter increments every instruction except I/O transfer, program transfer and sector jump
// - clear-and-load passes new operand unchanged
// - product and input data replace stored operand
// - low-order shift returns early through adder
// - high-order shift returns late via transfer register
// - idle loop keeps operand, increments counter
// - transfer loads counter; jump also loads operand
// - multiply takes 15 phase times, counter ends
// - multiply loads 24 high-order operand bits
// - multiply shifts right four places per cycle
// - latch five low multiplier bits every other phase
// - new partial product is sixteenth of sum
// - two multiples chosen from low multiplier bits
// - divide takes 27 phase times, counter ends
// - divide loads full 26-bit divisor and dividend
// - quotient bit one when signs agree
// - first quotient bit complemented when stored
// - divide shifts left two places per cycle
// - form both borrow and carry, select by bit
// - second bit and sign from borrow
// - result held until next multiply or divide
module sau_unit
   import sau_pkg::*;
(
   input wire logic CLK, // 100 MHz clock
   input wire logic RST_B, // asynchronous reset, active low
   input wire sau_cmd_t CMD, // accumulator loop command
   input wire sau_md_cmd_t MD_CMD, // multiply/divide start
   output logic [WORD_W-1:0] ACC_OUT, // stored operand
   output logic [IC_W-1:0] IC_OUT, // instruction counter
   output logic [WORD_W-1:0] MD_RESULT, // product/quotient register
   output logic MD_BUSY, // multiply/divide in progress
   output logic MD_DONE, // one-cycle end pulse
   output logic XFER_BUSY // high-order shift in transfer register
);

   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!RST_B);

   // accumulator loop state
   logic [WORD_W-1:0] acc_r; // stored operand
   logic [WORD_W-1:0] acc_nxt; // next stored operand
   logic [IC_W-1:0] ic_r; // instruction counter
   logic [IC_W-1:0] ic_nxt; // next counter
   logic [WORD_W-1:0] xfer_r; // transfer register copy
   logic xfer_pend_r; // shifted word waiting to return
   logic cmd_go; // command accepted this pass

   // multiply/divide state
   sau_md_mode_t md_mode_r; // current element mode
   logic [CNT_W-1:0] phase_r; // phase counter
   logic md_busy_r; // busy flag for the port
   logic md_done_r; // end pulse
   logic [WORD_W-1:0] md_result_r; // addressable result
   logic md_step; // odd phase: do a step
   logic md_latch; // even phase: relatch low bits

   // multiply channels
   logic signed [MUL_W-1:0] mcand_r; // multiplicand channel
   logic [MUL_W-1:0] mplier_r; // multiplier channel
   logic signed [PP_W-1:0] pp_r; // partial product channel
   logic [4:0] mr_latch_r; // latched five low multiplier bits
   logic multiplier_low_bit_r; // bit shifted past the low end
   logic signed [PP_W-1:0] delta1; // first multiple
   logic signed [PP_W-1:0] delta2; // second multiple
   logic signed [PP_W-1:0] pp_sum; // sum before the divide by 16
   logic [2*MUL_W-1:0] prod_full; // double-length product

   // divide channels
   logic signed [WORD_W-1:0] dvsr_r; // divisor channel
   logic signed [REM_W-1:0] rem_r; // remainder channel
   logic [QUO_W-1:0] quo_r; // quotient channel
   logic first_r; // next step yields the sign bit
   logic signed [REM_W-1:0] dv_ext; // sign-extended divisor
   logic signed [REM_W-1:0] r_less; // 2R - DV
   logic signed [REM_W-1:0] r_more; // 2R + DV
   logic signed [REM_W-1:0] r_mid; // remainder after first bit
   logic signed [REM_W-1:0] r2_less; // 2R' - DV
   logic signed [REM_W-1:0] r2_more; // 2R' + DV
   logic q_a; // first bit of the pair
   logic q_b; // second bit of the pair
   logic borrow_b; // borrow into the sign position
   logic sign_b; // sign of 2R - DV from the borrow

   // a pending high-order shift takes the pass; the command is dropped
   assign cmd_go = CMD.valid && !xfer_pend_r;

   // adder/subtractor and loop gating
   always_comb
   begin
      acc_nxt = acc_r; // idle pass leaves operand alone
      ic_nxt = ic_r + IC_STEP; // counter updated each pass
      if (xfer_pend_r)
      begin
         acc_nxt = xfer_r; // late return enters as new operand
      end
      else if (CMD.valid)
      begin
         case (CMD.op)
            SAU_OP_ADD: acc_nxt = acc_r + CMD.operand;
            SAU_OP_SUB: acc_nxt = acc_r - CMD.operand;
            SAU_OP_REVERSE_SUBTRACT:
               acc_nxt = CMD.operand - acc_r;
            SAU_OP_LOAD_CLEAR: acc_nxt = CMD.operand;
            SAU_OP_AND: acc_nxt = acc_r & CMD.operand;
            SAU_OP_XOR: acc_nxt = acc_r ^ CMD.operand;
            SAU_OP_SHIFT:
            begin
               // low-order direction comes straight back round
               if (!CMD.high_order_shift)
               begin
                  acc_nxt = CMD.shift_two ?
                     {{2{acc_r[WORD_W-1]}}, acc_r[WORD_W-1:2]} :
                     {acc_r[WORD_W-1], acc_r[WORD_W-1:1]};
               end
            end
            SAU_OP_LOAD_RESULT: acc_nxt = md_result_r;
            SAU_OP_IO_TRANSFER:
            begin
               acc_nxt = CMD.operand;
               ic_nxt = ic_r;
            end
            SAU_OP_PROGRAM_TRANSFER: ic_nxt = CMD.new_ic;
            SAU_OP_SECTOR_JUMP:
            begin
               acc_nxt = CMD.operand;
               ic_nxt = CMD.new_ic;
            end
            default: acc_nxt = acc_r; // no op: plain circulation
         endcase
      end
   end

   // accumulator register and counter
   always_ff @(posedge CLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         acc_r <= ACC_RST;
         ic_r <= IC_RST;
      end
      else
      begin
         acc_r <= acc_nxt;
         ic_r <= ic_nxt;
      end
   end

   // transfer register path for high-order shifts
   always_ff @(posedge CLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         xfer_r <= ACC_RST;
         xfer_pend_r <= 1'b0;
      end
      else if (cmd_go && CMD.op == SAU_OP_SHIFT && CMD.high_order_shift)
      begin
         xfer_r <= CMD.shift_two ? {acc_r[WORD_W-3:0], 2'b00} :
            {acc_r[WORD_W-2:0], 1'b0};
         xfer_pend_r <= 1'b1;
      end
      else
      begin
         xfer_pend_r <= 1'b0;
      end
   end

   // phase timing: steps on odd phases, relatch on even ones; the last
   // three phases are access time: six multiply, twelve divide steps
   assign md_step = phase_r[0] &&
      ((md_mode_r == SAU_MD_MUL && phase_r < MUL_LAST - 5'h02) ||
       (md_mode_r == SAU_MD_DIV && phase_r < DIV_LAST - 5'h02));
   assign md_latch = (md_mode_r == SAU_MD_MUL) && !phase_r[0];

   // phase counter and element control, apart from the loop
   always_ff @(posedge CLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         md_mode_r <= SAU_MD_IDLE;
         phase_r <= '0;
         md_busy_r <= 1'b0;
         md_done_r <= 1'b0;
      end
      else
      begin
         md_done_r <= 1'b0;
         if (md_mode_r == SAU_MD_IDLE)
         begin
            // a start while busy is ignored
            if (MD_CMD.start)
            begin
               md_mode_r <= MD_CMD.divide ? SAU_MD_DIV : SAU_MD_MUL;
               phase_r <= '0;
               md_busy_r <= 1'b1;
            end
         end
         else if ((md_mode_r == SAU_MD_MUL && phase_r == MUL_LAST) ||
                  (md_mode_r == SAU_MD_DIV && phase_r == DIV_LAST))
         begin
            md_mode_r <= SAU_MD_IDLE;
            md_busy_r <= 1'b0;
            md_done_r <= 1'b1;
         end
         else
         begin
            phase_r <= phase_r + 5'h01;
         end
      end
   end

   // multiple selection from the latched bits
   always_comb
   begin
      case (mr_latch_r[2:0])
         3'h1, 3'h2: delta1 = PP_W'(mcand_r) <<< 1;
         3'h3: delta1 = PP_W'(mcand_r) <<< 2;
         3'h4: delta1 = -(PP_W'(mcand_r) <<< 2);
         3'h5, 3'h6: delta1 = -(PP_W'(mcand_r) <<< 1);
         default: delta1 = '0;
      endcase
      case (mr_latch_r[4:2])
         3'h1, 3'h2: delta2 = PP_W'(mcand_r) <<< 3;
         3'h3: delta2 = PP_W'(mcand_r) <<< 4;
         3'h4: delta2 = -(PP_W'(mcand_r) <<< 4);
         3'h5, 3'h6: delta2 = -(PP_W'(mcand_r) <<< 3);
         default: delta2 = '0;
      endcase
      pp_sum = pp_r + delta1 + delta2;
   end

   assign prod_full = {pp_r[MUL_W-1:0], mplier_r};

   // multiply channels
   always_ff @(posedge CLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         mcand_r <= '0;
         mplier_r <= '0;
         pp_r <= '0;
         mr_latch_r <= 5'h00;
         multiplier_low_bit_r <= 1'b0;
      end
      else if (md_mode_r == SAU_MD_IDLE && MD_CMD.start && !MD_CMD.divide)
      begin
         mcand_r <= MD_CMD.mem_word[WORD_W-1:WORD_W-MUL_W];
         mplier_r <= acc_r[WORD_W-1:WORD_W-MUL_W];
         pp_r <= '0; // first cycle starts from zero
         mr_latch_r <= {acc_r[WORD_W-MUL_W+3:WORD_W-MUL_W], 1'b0};
         multiplier_low_bit_r <= 1'b0;
      end
      else if (md_mode_r == SAU_MD_MUL && md_step)
      begin
         pp_r <= pp_sum >>> 4;
         mplier_r <= {pp_sum[3:0], mplier_r[MUL_W-1:4]};
         multiplier_low_bit_r <= mplier_r[3];
      end
      else if (md_latch)
      begin
         mr_latch_r <= {mplier_r[3:0], multiplier_low_bit_r};
      end
   end

   // divide: both candidates formed, the quotient bit picks one
   always_comb
   begin
      dv_ext = REM_W'(dvsr_r);
      q_a = (rem_r[REM_W-1] == dvsr_r[WORD_W-1]);
      r_less = (rem_r <<< 1) - dv_ext;
      r_more = (rem_r <<< 1) + dv_ext;
      // borrow into the sign position of 2R - DV
      borrow_b = r_less[REM_W-1] ^ rem_r[REM_W-2] ^ dvsr_r[WORD_W-1];
      sign_b = rem_r[REM_W-2] ^ dvsr_r[WORD_W-1] ^ borrow_b;
      r_mid = q_a ? {sign_b, r_less[REM_W-2:0]} : r_more;
      r2_less = (r_mid <<< 1) - dv_ext;
      r2_more = (r_mid <<< 1) + dv_ext;
      q_b = q_a ? !(rem_r[REM_W-2] ^ borrow_b) :
         (r_more[REM_W-1] == dvsr_r[WORD_W-1]);
   end

   // divide channels
   always_ff @(posedge CLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         dvsr_r <= '0;
         rem_r <= '0;
         quo_r <= '0;
         first_r <= 1'b0;
      end
      else if (md_mode_r == SAU_MD_IDLE && MD_CMD.start && MD_CMD.divide)
      begin
         dvsr_r <= MD_CMD.mem_word;
         rem_r <= REM_W'(signed'(acc_r));
         quo_r <= '0;
         first_r <= 1'b1;
      end
      else if (md_mode_r == SAU_MD_DIV && md_step)
      begin
         rem_r <= q_b ? r2_less : r2_more;
         quo_r <= {quo_r[QUO_W-3:0], first_r ? !q_a : q_a, q_b};
         first_r <= 1'b0;
      end
   end

   // result register, replaced only at the end of an operation
   always_ff @(posedge CLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         md_result_r <= ACC_RST;
      end
      else if (md_mode_r == SAU_MD_MUL && phase_r == MUL_LAST)
      begin
         md_result_r <= prod_full[PROD_MSB:PROD_LSB];
      end
      else if (md_mode_r == SAU_MD_DIV && phase_r == DIV_LAST)
      begin
         md_result_r <= {quo_r, 2'b00};
      end
   end

   assign ACC_OUT = acc_r;
   assign IC_OUT = ic_r;
   assign MD_RESULT = md_result_r;
   assign MD_BUSY = md_busy_r;
   assign MD_DONE = md_done_r;
   assign XFER_BUSY = xfer_pend_r;

   // start sequences of the element
   sequence s_mul_start;
      md_mode_r == SAU_MD_IDLE && MD_CMD.start && !MD_CMD.divide;
   endsequence
   sequence s_div_start;
      md_mode_r == SAU_MD_IDLE && MD_CMD.start && MD_CMD.divide;
   endsequence

   a_add_result: assert property (cmd_go && CMD.op == SAU_OP_ADD
      |=> acc_r == $past(acc_r) + $past(CMD.operand))
      else $error("add result wrong");
   a_clear_load: assert property (cmd_go
      && CMD.op == SAU_OP_LOAD_CLEAR
      |=> acc_r == $past(CMD.operand))
      else $error("clear-and-load did not pass operand");
   a_io_hold: assert property (cmd_go
      && CMD.op == SAU_OP_IO_TRANSFER
      |=> $stable(ic_r))
      else $error("counter moved during io transfer");
   a_idle_pass: assert property (!CMD.valid && !xfer_pend_r
      |=> $stable(acc_r) && ic_r == $past(ic_r) + IC_STEP)
      else $error("idle pass wrong");
   a_jump_load: assert property (cmd_go
      && CMD.op == SAU_OP_SECTOR_JUMP
      |=> ic_r == $past(CMD.new_ic) && acc_r == $past(CMD.operand))
      else $error("sector jump load wrong");
   a_lsd_early: assert property (cmd_go && CMD.op == SAU_OP_SHIFT
      && !CMD.high_order_shift && !CMD.shift_two
      |=> acc_r == {$past(acc_r[WORD_W-1]), $past(acc_r[WORD_W-1:1])})
      else $error("low-order shift not early");
   a_msd_late: assert property (cmd_go && CMD.op == SAU_OP_SHIFT
      && CMD.high_order_shift && !CMD.shift_two
      |=> xfer_pend_r ##1 acc_r == {$past(acc_r[WORD_W-2:0], 2), 1'b0})
      else $error("high-order shift not late");
   a_mul_time: assert property (s_mul_start
      |=> md_busy_r [*8] ##7 (md_busy_r && !md_done_r)
      ##1 (md_done_r && !md_busy_r))
      else $error("multiply length wrong");
   a_div_time: assert property (s_div_start
      |=> ##26 md_busy_r ##1 (md_done_r && !md_busy_r))
      else $error("divide length wrong");
   a_result_hold: assert property ($changed(md_result_r)
      |-> md_done_r)
      else $error("result changed mid-operation");
   a_acc_concurrent: assert property (md_busy_r && cmd_go
      && CMD.op == SAU_OP_XOR
      |=> acc_r == ($past(acc_r) ^ $past(CMD.operand)))
      else $error("accumulator blocked by multiply/divide");

endmodule

// >>> core/sau_pkg.sv
// shared types and constants for the serial arithmetic unit
package sau_pkg;

   localparam int WORD_W = 26; // accumulator / memory word width
   localparam int IC_W = 8; // stored instruction counter width
   localparam int MUL_W = 24; // high-order bits used by multiply
   localparam int QUO_W = 24; // quotient bits produced by divide
   localparam int PP_W = 30; // partial product width with headroom
   localparam int REM_W = 28; // remainder width with headroom
   localparam int CNT_W = 5; // phase counter width

   // phase times per operation, instruction access included
   localparam logic [CNT_W-1:0] MUL_PHASES = 5'h0f;
   localparam logic [CNT_W-1:0] DIV_PHASES = 5'h1b;
   localparam logic [CNT_W-1:0] MUL_LAST = MUL_PHASES - 5'h01;
   localparam logic [CNT_W-1:0] DIV_LAST = DIV_PHASES - 5'h01;

   // reset values
   localparam logic [WORD_W-1:0] ACC_RST = 26'h0000000;
   localparam logic [IC_W-1:0] IC_RST = 8'h00;
   localparam logic [IC_W-1:0] IC_STEP = 8'h01;

   // product field taken from the 48-bit double word
   localparam int PROD_MSB = 47;
   localparam int PROD_LSB = 22;

   // accumulator loop operations
   typedef enum logic [3:0] {
      SAU_OP_NONE,
      SAU_OP_ADD,
      SAU_OP_SUB,
      SAU_OP_REVERSE_SUBTRACT,
      SAU_OP_LOAD_CLEAR,
      SAU_OP_AND,
      SAU_OP_XOR,
      SAU_OP_SHIFT,
      SAU_OP_LOAD_RESULT,
      SAU_OP_IO_TRANSFER,
      SAU_OP_PROGRAM_TRANSFER,
      SAU_OP_SECTOR_JUMP
   } sau_op_t;

   // multiply/divide element modes
   typedef enum logic [1:0] {
      SAU_MD_IDLE,
      SAU_MD_MUL,
      SAU_MD_DIV
   } sau_md_mode_t;

   // one accumulator loop command per clock
   typedef struct packed {
      logic valid; // command present
      sau_op_t op; // operation
      logic [WORD_W-1:0] operand; // new operand / input data
      logic high_order_shift; // shift toward high order (else low)
      logic shift_two; // shift two places (else one)
      logic [IC_W-1:0] new_ic; // counter for transfers and jumps
   } sau_cmd_t;

   // multiply/divide start request
   typedef struct packed {
      logic start; // begin an operation
      logic divide; // divide (else multiply)
      logic [WORD_W-1:0] mem_word; // addressed memory word
   } sau_md_cmd_t;

endpackage

// >>> tb/sau_pce_model.sv
// program control partner model presenting loop and md commands
module sau_pce_model
   import sau_pkg::*;
(
   XFER_BUSY, // transfer register occupied
   CMD, // accumulator loop command
   MD_CMD // multiply/divide start request
);
   timeunit 1ns;
   timeprecision 100ps;
   input wire logic XFER_BUSY;
   output sau_cmd_t CMD;
   output sau_md_cmd_t MD_CMD;

   // all lines idle at time zero
   initial
   begin
      CMD = '0;
      MD_CMD = '0;
   end

   // present a command; its valid is cleared while the transfer register is busy
   task automatic put(input sau_cmd_t c);
      sau_cmd_t t;
      t = c;
      t.valid = c.valid & ~XFER_BUSY;
      CMD = t;
   endtask

   // drop the command; released data toggles rather than holding
   task automatic cmd_off();
      sau_cmd_t t;
      t = CMD;
      t.valid = 1'b0;
      t.operand = ~CMD.operand;
      t.new_ic = ~CMD.new_ic;
      CMD = t;
   endtask

   // one-cycle start pulse with the addressed memory word
   task automatic md_start(input logic div, input logic [WORD_W-1:0] w);
      MD_CMD = '{start: 1'b1, divide: div, mem_word: w};
   endtask

   // end the start pulse; stale word inverted
   task automatic md_off();
      MD_CMD = '{start: 1'b0, divide: MD_CMD.divide,
                 mem_word: ~MD_CMD.mem_word};
   endtask
endmodule

// >>> tb/tb_top.sv
// self-checking bench for the serial arithmetic unit
module tb_top
   import sau_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int LIMIT = 3000; // cycle ceiling for the run
   logic CLK; // phase clock
   logic RST_B; // reset, active low
   sau_cmd_t cmd; // loop command from the partner
   sau_md_cmd_t md_cmd; // md start from the partner
   logic [WORD_W-1:0] acc_out; // stored operand
   logic [IC_W-1:0] ic_out; // instruction counter
   logic [WORD_W-1:0] md_result; // product/quotient register
   logic md_busy; // md in progress
   logic md_done; // md end pulse
   logic xfer_busy; // high-order shift pending
   int bad_count; // mismatches
   int total_checks; // comparisons
   int cyc; // cycles run
   logic [WORD_W-1:0] exp_acc; // modelled stored operand
   logic [WORD_W-1:0] exp_res; // modelled result register
   logic [IC_W-1:0] exp_ic; // modelled counter

   sau_unit uut (.CLK(CLK), .RST_B(RST_B), .CMD(cmd), .MD_CMD(md_cmd),
      .ACC_OUT(acc_out), .IC_OUT(ic_out), .MD_RESULT(md_result),
      .MD_BUSY(md_busy), .MD_DONE(md_done), .XFER_BUSY(xfer_busy));
   sau_pce_model pce (.XFER_BUSY(xfer_busy), .CMD(cmd), .MD_CMD(md_cmd));

   // free-running 100 MHz clock
   initial
   begin
      CLK = 1'b0;
      forever #5 CLK = ~CLK;
   end

   // verdict and end of run
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   // hang guard
   always @(posedge CLK)
   begin
      cyc++;
      if (cyc >= LIMIT)
      begin
         bad_count++;
         report_and_stop();
      end
   end

   // single comparison point
   task automatic chk(input string what, input logic [WORD_W-1:0] seen,
                      input logic [WORD_W-1:0] want);
      total_checks++;
      if (seen !== want)
      begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", what, want, seen);
      end
   endtask

   // one pass: counter advances on every rising edge
   task automatic step();
      @(negedge CLK);
      exp_ic = exp_ic + IC_STEP;
   endtask

   // one loop command, judged on the following cycle
   task automatic acc_op(input sau_op_t o, input logic [WORD_W-1:0] v,
                         input logic [IC_W-1:0] nic);
      sau_cmd_t c;
      logic [WORD_W-1:0] a;
      c = '{valid: 1'b1, op: o, operand: v, high_order_shift: 1'b0,
            shift_two: 1'b0, new_ic: nic};
      case (o)
         SAU_OP_ADD: a = exp_acc + v;
         SAU_OP_SUB: a = exp_acc - v;
         SAU_OP_REVERSE_SUBTRACT: a = v - exp_acc;
         SAU_OP_AND: a = exp_acc & v;
         SAU_OP_XOR: a = exp_acc ^ v;
         SAU_OP_LOAD_RESULT: a = exp_res;
         SAU_OP_LOAD_CLEAR, SAU_OP_IO_TRANSFER, SAU_OP_SECTOR_JUMP: a = v;
         default: a = exp_acc; // idle and counter transfer keep it
      endcase
      pce.put(c);
      step();
      if (o == SAU_OP_IO_TRANSFER)
         exp_ic = exp_ic - IC_STEP;
      if (o == SAU_OP_PROGRAM_TRANSFER || o == SAU_OP_SECTOR_JUMP)
         exp_ic = nic;
      exp_acc = a;
      chk("acc", acc_out, exp_acc);
      chk("ic", WORD_W'(ic_out), WORD_W'(exp_ic));
   endtask

   // every loop op except shift and result load, back to back
   task automatic test_ops();
      sau_op_t ops[10] = '{SAU_OP_LOAD_CLEAR, SAU_OP_ADD, SAU_OP_SUB,
         SAU_OP_REVERSE_SUBTRACT, SAU_OP_AND, SAU_OP_XOR, SAU_OP_NONE,
         SAU_OP_IO_TRANSFER, SAU_OP_PROGRAM_TRANSFER, SAU_OP_SECTOR_JUMP};
      for (int i = 0; i < 10; i++)
         acc_op(ops[i], 26'h2f0f0f3 + WORD_W'(i) * 26'h0511111,
                8'h30 + IC_W'(i));
      $display("test ops done");
   endtask

   // shift in both directions, one and two places
   task automatic shift_op(input logic high, input logic two);
      sau_cmd_t c;
      logic [WORD_W-1:0] a;
      c = '0;
      c.valid = 1'b1;
      c.op = SAU_OP_SHIFT;
      c.high_order_shift = high;
      c.shift_two = two;
      if (high)
         a = exp_acc << (two ? 2 : 1);
      else
         a = $signed(exp_acc) >>> (two ? 2 : 1);
      pce.put(c);
      step();
      if (high)
      begin
         chk("xfer busy", WORD_W'(xfer_busy), 26'h0000001);
         chk("acc early", acc_out, exp_acc);
         pce.cmd_off();
         step();
         chk("xfer free", WORD_W'(xfer_busy), 26'h0000000);
      end
      exp_acc = a;
      chk("shifted", acc_out, exp_acc);
      chk("ic shift", WORD_W'(ic_out), WORD_W'(exp_ic));
   endtask

   // idle passes with counter wrap
   task automatic test_idle();
      acc_op(SAU_OP_PROGRAM_TRANSFER, 26'h0000000, 8'hfd);
      repeat (5)
      begin
         pce.cmd_off();
         step();
      end
      chk("idle acc", acc_out, exp_acc);
      chk("idle ic", WORD_W'(ic_out), WORD_W'(exp_ic));
      $display("test idle done");
   endtask

   // run one md operation with loop traffic and a refused restart
   task automatic md_run(input logic div, input logic [WORD_W-1:0] w,
                         input int last);
      int n;
      n = 0;
      pce.md_start(div, w);
      do
      begin
         if (n < 3)
            acc_op(n == 1 ? SAU_OP_XOR : SAU_OP_ADD, 26'h0000011,
                   8'h00);
         else
         begin
            pce.cmd_off();
            step();
         end
         n++;
         if (n == 1 || n == 5)
            pce.md_off();
         if (n == 4)
            pce.md_start(~div, ~w);
         if (md_done !== 1'b1)
         begin
            chk("md busy", WORD_W'(md_busy), 26'h0000001);
            chk("held", md_result, exp_res);
         end
      end
      while (md_done !== 1'b1 && n < 40);
      chk("done cycle", WORD_W'(n), WORD_W'(last));
      chk("busy at end", WORD_W'(md_busy), 26'h0000000);
   endtask

   // multiply against the full signed product
   task automatic mul_test(input logic [WORD_W-1:0] m,
                           input logic [WORD_W-1:0] r);
      longint p;
      logic [63:0] pb;
      acc_op(SAU_OP_LOAD_CLEAR, r, 8'h00);
      // multiples of 2M to 16M put the product one place up
      p = 2 * longint'($signed(m[25:2])) * longint'($signed(r[25:2]));
      pb = p;
      md_run(1'b0, m, int'(MUL_PHASES) + 1);
      chk("product", md_result, pb[PROD_MSB:PROD_LSB]);
      exp_res = pb[PROD_MSB:PROD_LSB];
      acc_op(SAU_OP_LOAD_RESULT, 26'h0000000, 8'h00);
      $display("test multiply done");
   endtask

   // non-restoring divide, first quotient bit stored complemented
   task automatic div_test(input logic [WORD_W-1:0] d,
                           input logic [WORD_W-1:0] r);
      longint rem;
      longint dv;
      logic q;
      logic [QUO_W-1:0] qv;
      acc_op(SAU_OP_LOAD_CLEAR, r, 8'h00);
      rem = longint'($signed(r));
      dv = longint'($signed(d));
      qv = '0;
      for (int i = 0; i < QUO_W; i++)
      begin
         q = ((rem < 0) == (dv < 0));
         rem = 2 * rem + (q ? -dv : dv);
         qv = {qv[QUO_W-2:0], (i == 0) ? ~q : q};
      end
      md_run(1'b1, d, int'(DIV_PHASES) + 1);
      chk("quotient", md_result, {qv, 2'b00});
      exp_res = {qv, 2'b00};
      acc_op(SAU_OP_LOAD_RESULT, 26'h0000000, 8'h00);
      $display("test divide done");
   endtask

   // main sequence
   initial
   begin
      RST_B = 1'b0;
      bad_count = 0;
      total_checks = 0;
      cyc = 0;
      exp_acc = ACC_RST;
      exp_res = '0;
      exp_ic = IC_RST;
      repeat (2) @(negedge CLK);
      chk("rst acc", acc_out, ACC_RST);
      chk("rst ic", WORD_W'(ic_out), WORD_W'(IC_RST));
      chk("rst res", md_result, 26'h0000000);
      chk("rst flags", WORD_W'({md_busy, md_done, xfer_busy}), 26'h0);
      $display("test reset done");
      RST_B = 1'b1;
      test_ops();
      acc_op(SAU_OP_LOAD_CLEAR, 26'h2c3a5b7, 8'h00);
      shift_op(1'b0, 1'b0);
      shift_op(1'b0, 1'b1);
      shift_op(1'b1, 1'b0);
      shift_op(1'b1, 1'b1);
      acc_op(SAU_OP_XOR, 26'h1555555, 8'h00);
      $display("test shift done");
      test_idle();
      mul_test(26'h1234564, 26'h2b6d9f8);
      mul_test(26'h3f00000, 26'h0123450);
      mul_test(26'h2000000, 26'h2000000);
      div_test(26'h1000000, 26'h0400000);
      div_test(26'h0800000, 26'h3c00000);
      div_test(26'h3000000, 26'h0a5a5a4);
      report_and_stop();
   end
endmodule
